//--- frb_pkg.sv
//
// Function
// - Preamble enable set: 16-bit training pattern placed in read dummy cycles.
// - Pattern select bit chooses between two preamble patterns.
// - Preamble enabled: pre-drive period first, then training pattern bits.
// - Octal: all lines equal except line 3, different when pattern select is zero.
// - Single-rate octal, 20 dummy cycles: all sixteen bits right after pre-drive.
// - Too few dummy cycles: trailing preamble bits are cut off.
// - Double-rate octal, 12 dummy cycles: full sixteen bits right after pre-drive.
// - Wrap byte 01h/02h/03h gives 16/32/64 bytes; 1xh disables; 00h reserved.
// - Wrap burst starts anywhere and stays within its selected unit.
// - Wrap disabled after power-up; reads run linearly.
// - Wrap setting kept until 1xh, power down or reset; 01h-03h change depth.
// - Boot enabled: automatic read after power-on, reset command or hardware reset; power-on loads bit 0 as 1, so only the two resets start a boot.
// - Boot: first chip select gives data from boot address after delay cycles.
// - Chip select released after boot: back to normal command mode.
// - Single-bit mode always uses 13 boot delay cycles.
// - Octal boot delay field: 00=11, 01=15, 10=17, 11=21 cycles.
// - Boot register bits 31..4 hold 16-byte aligned start address, default ones.
// - Boot register bit 0 enables boot when 0; default 1; bit 3 reads 1.
// - Boot register written, erased and read back by commands.
package frb_pkg;

    typedef enum logic [3:0] {
        ST_IDLE, ST_OPCODE, ST_WRAPB, ST_ADDR, ST_DUMMY, ST_BOOT,
        ST_DATA, ST_REGOUT, ST_BWR, ST_HOLD
    } frb_state_e;

    // ----------------------------------------------------------------
    // Command opcodes
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_WRAP_SET         = 8'hc0;
    localparam logic [7:0] CMD_READ             = 8'h0c;
    localparam logic [7:0] BOOT_SETUP_WRITE_CMD = 8'h42;
    localparam logic [7:0] BOOT_SETUP_ERASE_CMD = 8'h43;
    localparam logic [7:0] BOOT_SETUP_READ_CMD  = 8'h16;
    localparam logic [7:0] CMD_RESET_DEV        = 8'h99;

    // ----------------------------------------------------------------
    // Boot register layout
    // ----------------------------------------------------------------
    localparam logic [31:0] BOOT_SETUP_RESET = 32'hffff_ffff;
    localparam int          BOOT_EN_N_POS    = 0;
    localparam int          BOOT_DLY_LSB     = 1;
    localparam int          BOOT_RSV_POS     = 3;
    localparam int          BOOT_ADDR_LSB    = 4;

    localparam logic [5:0] DLY_SERIAL = 6'd13;
    localparam logic [5:0] DLY_SEL_00 = 6'd11;
    localparam logic [5:0] DLY_SEL_01 = 6'd15;
    localparam logic [5:0] DLY_SEL_10 = 6'd17;
    localparam logic [5:0] DLY_SEL_11 = 6'd21;

    // ----------------------------------------------------------------
    // Preamble
    // ----------------------------------------------------------------
    localparam logic [4:0]  PRE_BITS       = 5'd16;
    localparam logic [5:0]  STR_FULL_DUMMY = 6'd20;
    localparam logic [5:0]  DTR_FULL_DUMMY = 6'd12;
    localparam logic [5:0]  PREDRIVE_STR   = STR_FULL_DUMMY - 6'd16;
    localparam logic [5:0]  PREDRIVE_DTR   = DTR_FULL_DUMMY - 6'd8;
    localparam logic [15:0] PAT_SEL0       = 16'h3a5c;
    localparam logic [15:0] PAT_SEL0_LINE3 = ~PAT_SEL0;
    localparam logic [15:0] PAT_SEL1       = 16'h00ff;

    // ----------------------------------------------------------------
    // Wrap and framing
    // ----------------------------------------------------------------
    localparam logic [1:0] WRAP_OFF   = 2'd0;
    localparam logic [2:0] ADDR_BYTES = 3'd4;
    localparam logic [2:0] BOOT_BYTES = 3'd4;
    localparam logic [7:0] OE_N_ALL   = 8'hff;
    localparam logic [7:0] OE_N_SO    = 8'hfd;
    localparam logic [7:0] OE_N_OCT   = 8'h00;

    typedef struct packed {
        logic       octal_single_rate_mode;
        logic       octal_double_rate_mode;
        logic       preamble_en;
        logic       pattern_select_bit;
        logic [5:0] dummy_cycles;
    } frb_cfg_s;

endpackage : frb_pkg

//--- frb_top.sv
`timescale 1ns/1ns
module frb_top (
    input  wire logic              MCLK_IN,
    input  wire logic              RSTN_IN,
    input  wire logic              CS_N_IN,
    input  wire logic              SCLK_IN,
    input  wire logic              HW_RESET_N_IN,
    input  wire logic [7:0]        LINES_IN,
    output logic      [7:0]        LINES_OUT,
    output logic      [7:0]        LINES_OE_N_OUT,
    input  wire frb_pkg::frb_cfg_s CFG_IN,
    output logic      [31:0]       MEM_ADDR_OUT,
    input  wire logic [7:0]        MEM_DATA_IN,
    output logic      [1:0]        WRAP_DEPTH_OUT,
    output logic      [31:0]       BOOT_SETUP_OUT
);
    import frb_pkg::*;

    typedef struct packed {
        frb_state_e      st;
        logic [2:0]      sclk_sy;
        logic [2:0]      cs_sy;
        logic [2:0]      hwr_sy;
        logic [2:0][7:0] lines_sy;
        logic            sclk_s;
        logic            sclk_p;
        logic            cs_n_s;
        logic            cs_n_p;
        logic            hwr_n_s;
        logic [7:0]      lines_s;
        logic [7:0]      shreg;
        logic [2:0]      bitcnt;
        logic [2:0]      obit;
        logic [2:0]      bytecnt;
        logic [7:0]      obyte;
        logic [31:0]     addr;
        logic [5:0]      cyc;
        logic [4:0]      pidx;
        logic [31:0]     boot;
        logic [1:0]      wrap;
        logic            boot_pend;
        logic [7:0]      lines_out;
        logic [7:0]      lines_oe_n;
    } frb_core_s;

    frb_core_s q, d;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] next_addr(input logic [31:0] a, input logic [1:0] w);
        logic [31:0] m;
        case (w)
            2'd1:    m = 32'h0000_000f;
            2'd2:    m = 32'h0000_001f;
            2'd3:    m = 32'h0000_003f;
            default: m = 32'h0000_0000;
        endcase
        if (w == WRAP_OFF) begin
            next_addr = a + 32'h1;
        end else begin
            next_addr = (a & ~m) | ((a + 32'h1) & m);
        end
    endfunction : next_addr

    function automatic logic [5:0] boot_delay(input logic ser, input logic [1:0] sel);
        if (ser) begin
            boot_delay = DLY_SERIAL;
        end else begin
            case (sel)
                2'b00:   boot_delay = DLY_SEL_00;
                2'b01:   boot_delay = DLY_SEL_01;
                2'b10:   boot_delay = DLY_SEL_10;
                default: boot_delay = DLY_SEL_11;
            endcase
        end
    endfunction : boot_delay

    function automatic logic [7:0] pattern_byte(input logic sel, input logic [3:0] idx);
        logic p;
        logic p3;
        p  = sel ? PAT_SEL1[4'd15 - idx] : PAT_SEL0[4'd15 - idx];
        p3 = sel ? p : PAT_SEL0_LINE3[4'd15 - idx];
        pattern_byte = {p, p, p, p, p3, p, p, p};
    endfunction : pattern_byte

    function automatic logic [7:0] boot_byte(input logic [31:0] b, input logic [1:0] i);
        case (i)
            2'd0:    boot_byte = b[31:24];
            2'd1:    boot_byte = b[23:16];
            2'd2:    boot_byte = b[15:8];
            default: boot_byte = b[7:0];
        endcase
    endfunction : boot_byte

    // ----------------------------------------------------------------
    // Link decode
    // ----------------------------------------------------------------
    logic       spi;
    logic       dtr;
    logic       rise;
    logic       fall;
    logic       ibeat;
    logic       obeat;
    logic       cs_fall;
    logic       cs_rise;
    logic [7:0] in_byte;
    logic       byte_done;
    logic [5:0] predrive;
    logic [5:0] dly;
    logic [7:0] src;

    always_comb begin
        spi       = !CFG_IN.octal_single_rate_mode && !CFG_IN.octal_double_rate_mode;
        dtr       = CFG_IN.octal_double_rate_mode;
        rise      = q.sclk_s && !q.sclk_p;
        fall      = !q.sclk_s && q.sclk_p;
        ibeat     = dtr ? (rise || fall) : rise;
        obeat     = dtr ? (rise || fall) : fall;
        cs_fall   = !q.cs_n_s && q.cs_n_p;
        cs_rise   = q.cs_n_s && !q.cs_n_p;
        in_byte   = spi ? {q.shreg[6:0], q.lines_s[0]} : q.lines_s;
        byte_done = ibeat && (!spi || q.bitcnt == 3'd7);
        predrive  = dtr ? PREDRIVE_DTR : PREDRIVE_STR;
        dly       = boot_delay(spi, q.boot[BOOT_DLY_LSB+1:BOOT_DLY_LSB]);
        src       = (q.st == ST_REGOUT) ? boot_byte(q.boot, q.bytecnt[1:0]) : MEM_DATA_IN;
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        d = q;
        // Three-stage sync; only stages two and three are compared
        d.sclk_sy = {q.sclk_sy[1:0], SCLK_IN};
        d.cs_sy   = {q.cs_sy[1:0], CS_N_IN};
        d.hwr_sy  = {q.hwr_sy[1:0], HW_RESET_N_IN};
        d.lines_sy = {q.lines_sy[1:0], LINES_IN};
        if (q.sclk_sy[1] == q.sclk_sy[2]) begin
            d.sclk_s = q.sclk_sy[2];
        end
        if (q.cs_sy[1] == q.cs_sy[2]) begin
            d.cs_n_s = q.cs_sy[2];
        end
        if (q.hwr_sy[1] == q.hwr_sy[2]) begin
            d.hwr_n_s = q.hwr_sy[2];
        end
        d.lines_s = (q.lines_s & (q.lines_sy[1] ^ q.lines_sy[2]))
                  | (q.lines_sy[2] & ~(q.lines_sy[1] ^ q.lines_sy[2]));
        d.sclk_p = q.sclk_s;
        d.cs_n_p = q.cs_n_s;

        if (ibeat && spi) begin
            d.shreg  = in_byte;
            d.bitcnt = q.bitcnt + 3'd1;
        end

        case (q.st)
            ST_IDLE: begin
                if (cs_fall) begin
                    d.bitcnt    = 3'd0;
                    d.shreg     = 8'h00;
                    d.boot_pend = 1'b0;
                    d.cyc       = 6'd0;
                    d.obit      = 3'd0;
                    if (q.boot_pend && !q.boot[BOOT_EN_N_POS]) begin
                        d.st   = ST_BOOT;
                        d.addr = {q.boot[31:BOOT_ADDR_LSB], 4'h0};
                    end else begin
                        d.st = ST_OPCODE;
                    end
                end
            end
            ST_OPCODE: begin
                if (byte_done) begin
                    d.bytecnt = 3'd0;
                    d.obit    = 3'd0;
                    d.st      = ST_HOLD;
                    case (in_byte)
                        CMD_WRAP_SET: d.st = ST_WRAPB;
                        CMD_READ:     d.st = ST_ADDR;
                        BOOT_SETUP_WRITE_CMD: d.st = ST_BWR;
                        BOOT_SETUP_READ_CMD:  d.st = ST_REGOUT;
                        BOOT_SETUP_ERASE_CMD: d.boot = BOOT_SETUP_RESET;
                        CMD_RESET_DEV: begin
                            d.wrap      = WRAP_OFF;
                            d.boot_pend = 1'b1;
                        end
                        default: d.st = ST_HOLD;
                    endcase
                end
            end
            ST_WRAPB: begin
                if (byte_done) begin
                    d.st = ST_HOLD;
                    if (in_byte[7:4] == 4'h1) begin
                        d.wrap = WRAP_OFF;
                    end else if (in_byte[7:2] == 6'h00 && in_byte[1:0] != 2'd0) begin
                        d.wrap = in_byte[1:0];
                    end
                end
            end
            ST_ADDR: begin
                if (byte_done) begin
                    d.addr    = {q.addr[23:0], in_byte};
                    d.bytecnt = q.bytecnt + 3'd1;
                    d.cyc     = 6'd0;
                    d.pidx    = 5'd0;
                    if (q.bytecnt == ADDR_BYTES - 3'd1) begin
                        d.st = (CFG_IN.dummy_cycles == 6'd0) ? ST_DATA : ST_DUMMY;
                    end
                end
            end
            ST_BWR: begin
                if (byte_done) begin
                    d.addr    = {q.addr[23:0], in_byte};
                    d.bytecnt = q.bytecnt + 3'd1;
                    if (q.bytecnt == BOOT_BYTES - 3'd1) begin
                        d.boot = {q.addr[23:0], in_byte} | (32'h1 << BOOT_RSV_POS);
                        d.st   = ST_HOLD;
                    end
                end
            end
            ST_DUMMY: begin
                if (obeat && CFG_IN.preamble_en) begin
                    d.lines_oe_n = spi ? OE_N_SO : OE_N_OCT;
                    if (q.cyc < predrive) begin
                        d.lines_out = 8'h00;
                    end else if (q.pidx < PRE_BITS) begin
                        d.lines_out = pattern_byte(CFG_IN.pattern_select_bit, q.pidx[3:0]);
                        d.pidx      = q.pidx + 5'd1;
                    end else begin
                        d.lines_out = 8'h00;
                    end
                end
                if (rise) begin
                    d.cyc = q.cyc + 6'd1;
                    if (q.cyc + 6'd1 == CFG_IN.dummy_cycles) begin
                        d.st = ST_DATA;
                    end
                end
            end
            ST_BOOT: begin
                if (rise) begin
                    d.cyc = q.cyc + 6'd1;
                    if (q.cyc + 6'd1 == dly) begin
                        d.st = ST_DATA;
                    end
                end
            end
            ST_DATA, ST_REGOUT: begin
                if (obeat) begin
                    d.lines_oe_n = spi ? OE_N_SO : OE_N_OCT;
                    if (!spi) begin
                        d.lines_out = src;
                        d.addr    = next_addr(q.addr, q.wrap);
                        d.bytecnt = q.bytecnt + 3'd1;
                    end else begin
                        d.obit = q.obit + 3'd1;
                        if (q.obit == 3'd0) begin
                            d.lines_out = {6'h00, src[7], 1'b0};
                            d.obyte   = {src[6:0], 1'b0};
                            d.addr    = next_addr(q.addr, q.wrap);
                            d.bytecnt = q.bytecnt + 3'd1;
                        end else begin
                            d.lines_out = {6'h00, q.obyte[7], 1'b0};
                            d.obyte   = {q.obyte[6:0], 1'b0};
                        end
                    end
                    if (q.st == ST_REGOUT) begin
                        d.addr = q.addr;
                        if (spi && q.obit != 3'd0) begin
                            d.bytecnt = q.bytecnt;
                        end
                    end
                end
            end
            ST_HOLD: begin
                d.st = ST_HOLD;
            end
            default: begin
                d.st = ST_IDLE;
            end
        endcase

        // Chip select release always returns to command mode
        if (cs_rise) begin
            d.st         = ST_IDLE;
            d.lines_oe_n = OE_N_ALL;
        end
        if (!q.hwr_n_s) begin
            d.st        = ST_IDLE;
            d.wrap      = WRAP_OFF;
            d.boot_pend = 1'b1;
            d.lines_oe_n = OE_N_ALL;
        end
    end

    // Boot register is set to all ones by power-on and by the erase command, modelling its erased state
    always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            q           <= '0;
            q.st        <= ST_IDLE;
            q.sclk_sy   <= 3'b000;
            q.cs_sy     <= 3'b111;
            q.hwr_sy    <= 3'b111;
            q.cs_n_s    <= 1'b1;
            q.cs_n_p    <= 1'b1;
            q.hwr_n_s   <= 1'b1;
            q.boot      <= BOOT_SETUP_RESET;
            q.wrap      <= WRAP_OFF;
            q.boot_pend <= 1'b1;
            q.lines_oe_n <= OE_N_ALL;
        end else begin
            q <= d;
        end
    end

    assign LINES_OUT      = q.lines_out;
    assign LINES_OE_N_OUT = q.lines_oe_n;
    assign MEM_ADDR_OUT   = q.addr;
    assign WRAP_DEPTH_OUT = q.wrap;
    assign BOOT_SETUP_OUT = q.boot;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (!RSTN_IN);

    a_preamble_off_quiet: assert property (
        q.st == ST_DUMMY && !CFG_IN.preamble_en && !$past(cs_rise) |-> q.lines_oe_n == OE_N_ALL)
        else $error("Lines driven in dummy cycles without preamble");
    a_predrive_zero: assert property (
        q.st == ST_DUMMY && obeat && CFG_IN.preamble_en && q.cyc < predrive && !cs_rise
        && q.hwr_n_s |=> q.lines_out == 8'h00 && q.lines_oe_n != OE_N_ALL)
        else $error("Pre-drive period not driven low");
    a_pattern_bit: assert property (
        q.st == ST_DUMMY && obeat && CFG_IN.preamble_en && q.cyc >= predrive
        && q.pidx < PRE_BITS |=> q.lines_out[0] == (CFG_IN.pattern_select_bit ?
        PAT_SEL1[4'd15 - $past(q.pidx[3:0])] : PAT_SEL0[4'd15 - $past(q.pidx[3:0])]))
        else $error("Wrong preamble bit");
    a_line3_differs: assert property (
        q.st == ST_DUMMY && obeat && CFG_IN.preamble_en && q.cyc >= predrive
        && q.pidx < PRE_BITS && !CFG_IN.pattern_select_bit |=> q.lines_out[3] != q.lines_out[0])
        else $error("Line 3 equals other lines with pattern select zero");
    a_wrap_disable: assert property (
        q.st == ST_WRAPB && byte_done && in_byte[7:4] == 4'h1 |=> q.wrap == WRAP_OFF)
        else $error("Wrap not disabled by 1x setting");
    a_wrap_in_unit: assert property (
        q.wrap != WRAP_OFF && q.st == ST_DATA && $past(q.st) == ST_DATA && $changed(q.addr)
        |-> q.addr[31:6] == $past(q.addr[31:6]))
        else $error("Wrap burst left its unit");
    a_boot_start_addr: assert property (
        q.st == ST_IDLE && cs_fall && q.boot_pend && !q.boot[BOOT_EN_N_POS] && q.hwr_n_s
        |=> q.st == ST_BOOT && q.addr == {$past(q.boot[31:4]), 4'h0})
        else $error("Boot read not started at boot address");
    a_serial_boot_delay: assert property (
        q.st == ST_BOOT && spi && rise && q.cyc == 6'd12 && !cs_rise && q.hwr_n_s
        |=> q.st == ST_DATA)
        else $error("Serial boot delay not 13 cycles");
    a_cs_release_idle: assert property (
        cs_rise |=> q.st == ST_IDLE && q.lines_oe_n == OE_N_ALL)
        else $error("Chip select release did not return to idle");
    a_erase_ones: assert property (
        q.st == ST_OPCODE && byte_done && in_byte == BOOT_SETUP_ERASE_CMD
        |=> q.boot == BOOT_SETUP_RESET)
        else $error("Boot register not erased to ones");
    a_reserved_one: assert property (
        q.boot[BOOT_RSV_POS] == 1'b1)
        else $error("Reserved boot bit not one");

    c_preamble_run: cover property (q.st == ST_DUMMY && q.pidx == PRE_BITS);
    c_boot_data: cover property (q.st == ST_BOOT ##1 q.st == ST_DATA);
    c_wrap_set: cover property (q.st == ST_WRAPB && byte_done && in_byte == 8'h02);
    c_reg_readback: cover property (q.st == ST_REGOUT && q.bytecnt == 3'd4);

endmodule : frb_top

//--- frb_host.sv
`timescale 1ns/1ns
module frb_host (
    input  wire logic       mclk_in,
    input  wire logic [7:0] lines_in,
    output logic            cs_n_out,
    output logic            sclk_out,
    output logic      [7:0] drv_out
);
    logic [7:0]  cap;
    logic [31:0] got_d;
    logic        watch;
    int          n_got;
    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
        drv_out  = 8'h00;
        watch    = 1'b0;
        n_got    = 0;
    end
    // ----------------------------------------------------------------
    // Frame control
    // ----------------------------------------------------------------
    task start();
        @(posedge mclk_in) #1;
        cs_n_out = 1'b0;
    endtask : start
    // Released lines flip so a stale value never passes as valid
    task stop();
        #160 cs_n_out = 1'b1;
        drv_out = ~drv_out;
        #480;
    endtask : stop
    // Clock stands low outside frames; data set a half period before rise
    task cyc(input logic [7:0] d);
        drv_out = d;
        #160 sclk_out = 1'b1;
        #150 cap = lines_in;
        #10 sclk_out = 1'b0;
    endtask : cyc
    task note(input logic [7:0] v);
        if (watch) begin
            got_d = {24'h0, v};
            n_got++;
        end
    endtask : note
    task oct(input logic [7:0] d);
        cyc(d);
        note(cap);
    endtask : oct
    task ser_byte(input logic [7:0] b);
        logic [7:0] q;
        for (int i = 7; i >= 0; i--) begin
            cyc({7'h0, b[i]});
            q[i] = cap[1];
        end
        note(q);
    endtask : ser_byte
endmodule : frb_host

//--- testbench.sv
`timescale 1ns/1ns
module testbench;
    import frb_pkg::*;
    logic        mclk = 1'b0;
    logic        rstn = 1'b0;
    logic        hw_n = 1'b1;
    logic        cs_n;
    logic        sclk;
    logic [7:0]  drv;
    logic [7:0]  lines;
    logic [7:0]  lines_out;
    logic [7:0]  oe_n;
    logic [7:0]  mem_d;
    logic [7:0]  e;
    logic [15:0] p;
    logic [15:0] p3;
    logic [31:0] mem_a;
    logic [31:0] boot;
    logic [31:0] val;
    logic [31:0] a;
    logic [1:0]  wrap;
    frb_cfg_s    cfg = '0;
    int          bad_count = 0;
    int          comparisons = 0;
    int          n;
    logic [31:0] exp_q[$];
    logic [7:0]  wv[5] = '{8'h01, 8'h02, 8'h03, 8'h00, 8'h12};
    logic [1:0]  we[5] = '{2'd1, 2'd2, 2'd3, 2'd3, 2'd0};
    int          dly[4] = '{11, 15, 17, 21};
    assign lines = (~oe_n & lines_out) | (oe_n & drv);
    assign mem_d = mem_a[7:0] ^ 8'h5a;
    always #20 mclk = ~mclk;
    frb_top u_dut (.MCLK_IN(mclk), .RSTN_IN(rstn), .CS_N_IN(cs_n), .SCLK_IN(sclk),
        .HW_RESET_N_IN(hw_n), .LINES_IN(lines), .LINES_OUT(lines_out), .LINES_OE_N_OUT(oe_n),
        .CFG_IN(cfg), .MEM_ADDR_OUT(mem_a), .MEM_DATA_IN(mem_d),
        .WRAP_DEPTH_OUT(wrap), .BOOT_SETUP_OUT(boot));
    frb_host u_host (.mclk_in(mclk), .lines_in(lines), .cs_n_out(cs_n), .sclk_out(sclk),
        .drv_out(drv));
    // ----------------------------------------------------------------
    // Checking and closing
    // ----------------------------------------------------------------
    task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        comparisons++;
        if (g !== x) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, x, g);
        end
    endtask : chk
    always @(u_host.n_got) chk("link byte", exp_q.pop_front(), u_host.got_d);
    task wrap_up();
        if (bad_count == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : wrap_up
    task tick(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask : tick
    task cmd(input logic [7:0] op, input int nb, input logic [31:0] arg);
        u_host.start();
        u_host.ser_byte(op);
        for (int i = 0; i < nb; i++) u_host.ser_byte(arg[31-8*i -: 8]);
        u_host.stop();
    endtask : cmd
    initial begin
        #1_000_000;
        bad_count++;
        wrap_up();
    end
    initial begin
        void'($urandom(32'h65a37200));
        tick(12);
        rstn = 1'b1;
        tick(2);
        chk("boot reg", 32'hffff_ffff, boot);
        chk("wrap", 32'h0, {30'h0, wrap});
        for (int i = 0; i < 5; i++) begin
            cmd(CMD_WRAP_SET, 1, {wv[i], 24'h0});
            tick(2);
            chk("wrap", {30'h0, we[i]}, {30'h0, wrap});
        end
        // Bit 3 written as zero must still read back as one
        val = $urandom() & 32'hffff_fff0;
        cmd(BOOT_SETUP_WRITE_CMD, 4, val | 32'h2);
        tick(2);
        chk("boot reg", val | 32'ha, boot);
        u_host.start();
        u_host.ser_byte(BOOT_SETUP_READ_CMD);
        u_host.watch = 1'b1;
        for (int i = 0; i < 4; i++) begin
            exp_q.push_back({24'h0, val[31-8*i -: 8] | ((i == 3) ? 8'h0a : 8'h00)});
            u_host.ser_byte(8'h00);
        end
        u_host.watch = 1'b0;
        u_host.stop();
        cmd(CMD_RESET_DEV, 0, 32'h0);
        a = val;
        u_host.start();
        repeat (13) u_host.cyc(8'h00);
        u_host.watch = 1'b1;
        for (int i = 0; i < 2; i++) begin
            exp_q.push_back({24'h0, (a[7:0] + 8'(i)) ^ 8'h5a});
            u_host.ser_byte(8'h00);
        end
        u_host.watch = 1'b0;
        u_host.stop();
        cmd(BOOT_SETUP_ERASE_CMD, 0, 32'h0);
        tick(2);
        chk("boot reg", 32'hffff_ffff, boot);
        for (int s = 0; s < 4; s++) begin
            cfg = '0;
            cmd(BOOT_SETUP_WRITE_CMD, 4, val | 32'(s << 1));
            tick(1);
            cfg.octal_single_rate_mode = !s[0];
            cfg.octal_double_rate_mode = s[0];
            hw_n = 1'b0;
            tick(4);
            hw_n = 1'b1;
            tick(4);
            u_host.start();
            repeat (dly[s]) u_host.cyc(8'h00);
            u_host.watch = 1'b1;
            exp_q.push_back({24'h0, a[7:0] ^ 8'h5a});
            u_host.oct(8'h00);
            u_host.watch = 1'b0;
            u_host.stop();
        end
        cfg = '0;
        cmd(CMD_WRAP_SET, 1, 32'h0100_0000);
        a = 32'h0000_010e;
        for (int r = 0; r < 4; r++) begin
            n = (r == 2) ? 8 : ((r == 3) ? 11 : 20);
            p = r[0] ? PAT_SEL1 : PAT_SEL0;
            p3 = r[0] ? PAT_SEL1 : PAT_SEL0_LINE3;
            tick(1);
            cfg = '{1'b1, 1'b0, r != 3, r[0], 6'(n)};
            u_host.start();
            u_host.oct(CMD_READ);
            for (int i = 0; i < 4; i++) u_host.oct(a[31-8*i -: 8]);
            u_host.watch = 1'b1;
            // Host drives a5 in dummies; only a released bus lets it through
            for (int d = 0; d < n + 5; d++) begin
                e = (r == 3) ? 8'ha5 : 8'h00;
                if (d >= n) e = {a[7:4], a[3:0] + 4'(d - n)} ^ 8'h5a;
                else if (r != 3 && d >= 4) e = {{4{p[19-d]}}, p3[19-d], {3{p[19-d]}}};
                exp_q.push_back({24'h0, e});
                u_host.oct(8'ha5);
            end
            u_host.watch = 1'b0;
            u_host.stop();
        end
        chk("oe idle", 32'hff, {24'h0, oe_n});
        chk("queue left", 32'h0, exp_q.size());
        wrap_up();
    end
endmodule : testbench
